// ==== logic/sdcai_map.svh ====
// Widths, field positions, reset values and burst beat counts of the DRAM command interface.
`ifndef SDCAI_MAP_SVH
`define SDCAI_MAP_SVH
`define SDCAI_ROW_W        14
`define SDCAI_BANK_W       3
`define SDCAI_BANKS        8
`define SDCAI_DATA_W       16
`define SDCAI_AP_POS       10
`define SDCAI_BC_POS       12
`define SDCAI_MR1_ODT_LO   2
`define SDCAI_MR1_ODT_MID  6
`define SDCAI_MR1_ODT_HI   9
`define SDCAI_MR0_BL_LO    0
`define SDCAI_MR_RST       14'h0000
`define SDCAI_MR0_BL_OTF   2'h1
`define SDCAI_BL8_BEATS    4'h8
`define SDCAI_BC4_BEATS    4'h4
`endif

// ==== logic/sdcai_pkg.sv ====
// Types shared by the DRAM command and address interface.
package sdcai_pkg;
   typedef enum logic [2:0] {
      SDCAI_CMD_LMR   = 3'h0,
      SDCAI_CMD_REF   = 3'h1,
      SDCAI_CMD_PRE   = 3'h2,
      SDCAI_CMD_ACT   = 3'h3,
      SDCAI_CMD_WR    = 3'h4,
      SDCAI_CMD_RD    = 3'h5,
      SDCAI_CMD_ZQC   = 3'h6,
      SDCAI_CMD_NOP   = 3'h7
   } sdcai_cmd_t;

   typedef enum logic [1:0] {
      SDCAI_PW_ACTIVE = 2'h0,
      SDCAI_PW_PPD    = 2'h1,
      SDCAI_PW_APD    = 2'h2,
      SDCAI_PW_SREF   = 2'h3
   } sdcai_pw_t;

   typedef struct packed {
      logic        chip_select_n;
      logic        row_strobe_n;
      logic        column_strobe_n;
      logic        write_enable_n;
      logic [2:0]  bank_address;
      logic [13:0] address;
   } sdcai_ca_t;

   typedef struct packed {
      logic        write;
      logic [2:0]  bank;
      logic [13:0] row;
      logic [13:0] column;
      logic        auto_precharge;
      logic [3:0]  beats;
   } sdcai_access_t;

   typedef struct packed {
      logic [15:0] data;
      logic        lower_byte_mask;
      logic        upper_byte_mask;
   } sdcai_wbeat_t;
endpackage

// ==== logic/sdcai_top.sv ====
// Command, address and control decoder of a x16 synchronous DRAM.
`timescale 1ns/10ps
`include "sdcai_map.svh"
// Function
// - ACTIVATE brings the row address, READ/WRITE the column and auto-precharge bit.
// - PRECHARGE closes the addressed bank, or every bank with auto-precharge high.
// - LOAD MODE takes the op-code from the address inputs.
// - With on-the-fly chop enabled, burst_chop_bit high gives 8 beats, low 4.
// - ACTIVATE, READ, WRITE and single PRECHARGE act on the bank_address bank.
// - During LOAD MODE bank_address selects mode register 0 to 3.
// - All control and address inputs are sampled on the rising clock crossing.
// - The output data strobe is timed from the clock crossings.
// - Clock enable low enters precharge, active power-down or self refresh.
// - Clock enable is synchronous except for self-refresh exit, seen without clock.
// - In power-down only clock, clock enable, reset and termination inputs stay on.
// - In self refresh only clock enable and reset inputs stay on.
// - Commands are decoded only while chip_select_n is registered low.
// - The command is chip select and the three strobes on one edge.
// - A write beat with lower_byte_mask high leaves the lower byte unwritten.
// - Termination follows termination_enable on data lines, strobes and masks.
// - Termination disabled by mode register makes termination_enable ignored.
// - The active-low reset acts regardless of the clock.
// - Read strobe is edge-aligned to data; write strobe is center-aligned.
// - A write beat with upper_byte_mask high leaves the upper byte unwritten.
module sdcai_top #(
   parameter int ROW_W  = `SDCAI_ROW_W,
   parameter int DATA_W = `SDCAI_DATA_W
) (
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_link_ck,
   input  wire logic                   i_clock_enable_pin,
   input  wire logic                   i_reset_pin_n,
   input  wire logic                   i_termination_enable,
   input  wire sdcai_pkg::sdcai_ca_t   i_ca,
   input  wire sdcai_pkg::sdcai_wbeat_t i_wbeat,
   input  wire logic                   i_wbeat_valid,
   input  wire logic                   i_acc_ready,
   output logic                        o_acc_valid,
   output sdcai_pkg::sdcai_access_t    o_acc,
   output logic                        o_wbeat_valid,
   output logic [DATA_W-1:0]           o_wdata,
   output logic [1:0]                  o_byte_we,
   output logic [`SDCAI_BANKS-1:0]     o_bank_open,
   output logic [1:0]                  o_power_state,
   output logic                        o_ca_buf_en,
   output logic                        o_ck_buf_en,
   output logic                        o_odt_on,
   output logic                        o_strobe_toggle,
   output logic                        o_overflow
);
   import sdcai_pkg::*;

   // ***************************************************************
   // Input synchronisers and clock edge detection.
   // ***************************************************************
   logic [2:0] ck_sync_ff;
   logic [2:0] cke_sync_ff;
   logic [2:0] rstp_sync_ff;
   logic       ck_rise;
   logic       cke_s;
   logic       rstp_n_s;

   always_ff @(posedge i_mclk) begin
      ck_sync_ff   <= {ck_sync_ff[1:0], i_link_ck};
      cke_sync_ff  <= {cke_sync_ff[1:0], i_clock_enable_pin};
      rstp_sync_ff <= {rstp_sync_ff[1:0], i_reset_pin_n};
   end

   assign ck_rise  = ck_sync_ff[1] & ~ck_sync_ff[2];
   assign cke_s    = cke_sync_ff[2];
   assign rstp_n_s = rstp_sync_ff[1] & rstp_sync_ff[2];

   logic rst_all_n;
   assign rst_all_n = i_rst_n & rstp_n_s;

   // ***************************************************************
   // Command capture on the clock crossing.
   // ***************************************************************
   sdcai_ca_t  ca_ff;
   logic       cap_ff;
   logic       cke_reg_ff;
   logic       odt_reg_ff;

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         ca_ff      <= '{chip_select_n: 1'b1, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                         write_enable_n: 1'b1, bank_address: 3'h0, address: 14'h0000};
         cap_ff     <= 1'b0;
         cke_reg_ff <= 1'b0;
         odt_reg_ff <= 1'b0;
      end else begin
         cap_ff <= 1'b0;
         if (ck_rise) begin
            cke_reg_ff <= cke_s;
            if (o_ck_buf_en) begin
               odt_reg_ff <= i_termination_enable;
            end
            if (o_ca_buf_en) begin
               ca_ff  <= i_ca;
               cap_ff <= 1'b1;
            end
         end
      end
   end

   sdcai_cmd_t cmd;
   logic       acc_take;
   always_comb begin
      if (!cap_ff || ca_ff.chip_select_n) begin
         cmd = SDCAI_CMD_NOP;
      end else begin
         cmd = sdcai_cmd_t'({ca_ff.row_strobe_n, ca_ff.column_strobe_n,
                             ca_ff.write_enable_n});
      end
   end

   // ***************************************************************
   // Mode registers.
   // ***************************************************************
   logic [ROW_W-1:0] mr_ff [4];

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         for (int k = 0; k < 4; k++) begin
            mr_ff[k] <= `SDCAI_MR_RST;
         end
      end else if (cmd == SDCAI_CMD_LMR && ca_ff.bank_address[2] == 1'b0) begin
         mr_ff[ca_ff.bank_address[1:0]] <= ca_ff.address;
      end
   end

   logic otf_chop;
   logic odt_allowed;
   assign otf_chop = mr_ff[0][`SDCAI_MR0_BL_LO+:2] == `SDCAI_MR0_BL_OTF;
   assign odt_allowed = mr_ff[1][`SDCAI_MR1_ODT_LO] | mr_ff[1][`SDCAI_MR1_ODT_MID]
                      | mr_ff[1][`SDCAI_MR1_ODT_HI];

   // ***************************************************************
   // Bank state.
   // ***************************************************************
   logic [ROW_W-1:0] row_ff [`SDCAI_BANKS];

   genvar g;
   generate
      for (g = 0; g < `SDCAI_BANKS; g++) begin : g_bank
         always_ff @(posedge i_mclk) begin
            if (!rst_all_n) begin
               o_bank_open[g] <= 1'b0;
               row_ff[g]      <= '0;
            end else if (cmd == SDCAI_CMD_ACT && ca_ff.bank_address == g) begin
               o_bank_open[g] <= 1'b1;
               row_ff[g]      <= ca_ff.address;
            end else if (cmd == SDCAI_CMD_PRE &&
                         (ca_ff.address[`SDCAI_AP_POS] || ca_ff.bank_address == g)) begin
               o_bank_open[g] <= 1'b0;
            end else if ((cmd == SDCAI_CMD_RD || cmd == SDCAI_CMD_WR) && acc_take &&
                         ca_ff.bank_address == g && ca_ff.address[`SDCAI_AP_POS]) begin
               o_bank_open[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Access buffer of two entries towards the array.
   // ***************************************************************
   sdcai_access_t nxt_acc;
   sdcai_access_t buf_ff [2];
   logic [1:0]    cnt_ff;
   logic          rd_ptr_ff;
   logic          wr_ptr_ff;

   always_comb begin
      nxt_acc.write          = (cmd == SDCAI_CMD_WR);
      nxt_acc.bank           = ca_ff.bank_address;
      nxt_acc.row            = row_ff[ca_ff.bank_address];
      nxt_acc.column         = ca_ff.address;
      nxt_acc.auto_precharge = ca_ff.address[`SDCAI_AP_POS];
      if (otf_chop && !ca_ff.address[`SDCAI_BC_POS]) begin
         nxt_acc.beats = `SDCAI_BC4_BEATS;
      end else begin
         nxt_acc.beats = `SDCAI_BL8_BEATS;
      end
   end

   logic acc_req;
   logic acc_pop;
   assign acc_req  = (cmd == SDCAI_CMD_RD) || (cmd == SDCAI_CMD_WR);
   assign acc_take = acc_req && (cnt_ff != 2'h2);
   assign acc_pop  = o_acc_valid && i_acc_ready;

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         cnt_ff    <= 2'h0;
         rd_ptr_ff <= 1'b0;
         wr_ptr_ff <= 1'b0;
      end else begin
         if (acc_take) begin
            buf_ff[wr_ptr_ff] <= nxt_acc;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         if (acc_pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         cnt_ff <= cnt_ff + 2'(acc_take) - 2'(acc_pop);
      end
   end

   logic [1:0]    cnt_nxt;
   logic          rd_nxt;
   assign cnt_nxt = cnt_ff + 2'(acc_take) - 2'(acc_pop);
   assign rd_nxt  = rd_ptr_ff ^ acc_pop;

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         o_acc_valid <= 1'b0;
         o_acc       <= '0;
         o_overflow  <= 1'b0;
      end else begin
         o_acc_valid <= cnt_nxt != 2'h0;
         if (cnt_nxt != 2'h0) begin
            o_acc <= (acc_take && cnt_ff == 2'h0) || (acc_take && cnt_nxt == 2'h1 && acc_pop)
                     ? nxt_acc : buf_ff[rd_nxt];
         end
         if (acc_req && !acc_take) begin
            o_overflow <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Write data masking.
   // ***************************************************************
   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         o_wbeat_valid <= 1'b0;
         o_wdata       <= '0;
         o_byte_we     <= 2'h0;
      end else begin
         o_wbeat_valid <= i_wbeat_valid;
         o_wdata       <= i_wbeat.data;
         o_byte_we[0]  <= i_wbeat_valid && !i_wbeat.lower_byte_mask;
         o_byte_we[1]  <= i_wbeat_valid && !i_wbeat.upper_byte_mask;
      end
   end

   // ***************************************************************
   // Power state, input buffer gating and termination.
   // ***************************************************************
   sdcai_pw_t pw_ff;

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         pw_ff <= SDCAI_PW_ACTIVE;
      end else begin
         case (pw_ff)
            SDCAI_PW_ACTIVE: begin
               if (ck_rise && !cke_s && cke_reg_ff) begin
                  if (|o_bank_open) begin
                     pw_ff <= SDCAI_PW_APD;
                  end else if (!i_ca.chip_select_n && sdcai_cmd_t'({i_ca.row_strobe_n,
                               i_ca.column_strobe_n, i_ca.write_enable_n}) == SDCAI_CMD_REF) begin
                     pw_ff <= SDCAI_PW_SREF;
                  end else begin
                     pw_ff <= SDCAI_PW_PPD;
                  end
               end
            end
            SDCAI_PW_PPD, SDCAI_PW_APD: begin
               if (ck_rise && cke_s) begin
                  pw_ff <= SDCAI_PW_ACTIVE;
               end
            end
            SDCAI_PW_SREF: begin
               if (cke_s) begin
                  pw_ff <= SDCAI_PW_ACTIVE;
               end
            end
            default: pw_ff <= SDCAI_PW_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!rst_all_n) begin
         o_power_state   <= 2'h0;
         o_ca_buf_en     <= 1'b1;
         o_ck_buf_en     <= 1'b1;
         o_odt_on        <= 1'b0;
         o_strobe_toggle <= 1'b0;
      end else begin
         o_power_state   <= pw_ff;
         o_ca_buf_en     <= (pw_ff == SDCAI_PW_ACTIVE);
         o_ck_buf_en     <= (pw_ff != SDCAI_PW_SREF);
         o_odt_on        <= odt_allowed && odt_reg_ff && pw_ff != SDCAI_PW_SREF;
         if (ck_rise && pw_ff == SDCAI_PW_ACTIVE) begin
            o_strobe_toggle <= ~o_strobe_toggle;
         end
      end
   end
endmodule // sdcai_top

// ==== tb/sdcai_monitor.sv ====
// Port checker of the DRAM command interface.
`timescale 1ns/10ps
`include "sdcai_map.svh"
module sdcai_monitor #(
   parameter int ROW_W  = `SDCAI_ROW_W,
   parameter int DATA_W = `SDCAI_DATA_W
) (
   input wire logic                    i_mclk,
   input wire logic                    i_rst_n,
   input wire logic                    i_reset_pin_n,
   input wire logic                    i_link_ck,
   input wire sdcai_pkg::sdcai_ca_t    i_ca,
   input wire sdcai_pkg::sdcai_wbeat_t i_wbeat,
   input wire logic                    i_wbeat_valid,
   input wire logic                    i_acc_ready,
   input wire logic                    o_acc_valid,
   input wire sdcai_pkg::sdcai_access_t o_acc,
   input wire logic                    o_wbeat_valid,
   input wire logic [DATA_W-1:0]       o_wdata,
   input wire logic [1:0]              o_byte_we,
   input wire logic [`SDCAI_BANKS-1:0] o_bank_open,
   input wire logic [1:0]              o_power_state,
   input wire logic                    o_ca_buf_en,
   input wire logic                    o_ck_buf_en
);
   import sdcai_pkg::*;
   // ****
   // Checks
   // ****
   logic [3:0] cmd;
   assign cmd = {i_ca.chip_select_n, i_ca.row_strobe_n, i_ca.column_strobe_n, i_ca.write_enable_n};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n || !i_reset_pin_n);
   sequence cmd_at(logic [3:0] c);
      $rose(i_link_ck) && o_power_state == 2'h0 && cmd == c;
   endsequence
   act_open_a: assert property (
      cmd_at(4'h3) |-> ##[3:8] o_bank_open[i_ca.bank_address]) else $error("Bank not opened.");
   close_all_a: assert property (
      cmd_at(4'h2) ##0 i_ca.address[10] |-> ##[3:8] o_bank_open == '0) else $error("Banks open.");
   deselect_a: assert property (
      $rose(i_link_ck) && i_ca.chip_select_n |=> $stable(o_bank_open)[*8]) else $error("Deselect.");
   read_issue_a: assert property (
      cmd_at(4'h5) ##0 i_acc_ready |-> ##[3:8] o_acc_valid && !o_acc.write
      && o_acc.bank == i_ca.bank_address && o_acc.auto_precharge == i_ca.address[10])
      else $error("Read not issued.");
   acc_hold_a: assert property (
      o_acc_valid && !i_acc_ready |=> o_acc_valid && $stable(o_acc)) else $error("Access lost.");
   byte_mask_a: assert property (
      i_wbeat_valid && o_power_state == 2'h0 |=> o_wbeat_valid && o_wdata == $past(i_wbeat.data)
      && o_byte_we == ~{$past(i_wbeat.upper_byte_mask), $past(i_wbeat.lower_byte_mask)})
      else $error("Byte enables wrong.");
   sref_buf_a: assert property (
      o_power_state == 2'h3 && $past(o_power_state) == 2'h3 |-> !o_ck_buf_en && !o_ca_buf_en)
      else $error("Buffers on in self refresh.");
   pd_buf_a: assert property (
      o_power_state inside {2'h1, 2'h2} && $past(o_power_state) == o_power_state
      |-> o_ck_buf_en && !o_ca_buf_en) else $error("Buffers wrong in power-down.");
   pd_kind_a: assert property (
      o_power_state inside {2'h1, 2'h2} |-> (o_power_state == 2'h2) == (o_bank_open != '0))
      else $error("Power-down kind wrong.");
endmodule // sdcai_monitor
bind sdcai_top sdcai_monitor #(.ROW_W(ROW_W), .DATA_W(DATA_W)) u_sdcai_monitor (.i_mclk,
   .i_rst_n, .i_reset_pin_n, .i_link_ck, .i_ca, .i_wbeat, .i_wbeat_valid, .i_acc_ready,
   .o_acc_valid, .o_acc, .o_wbeat_valid, .o_wdata, .o_byte_we, .o_bank_open, .o_power_state,
   .o_ca_buf_en, .o_ck_buf_en);

// ==== tb/sdcai_ctrl_model.sv ====
// Controller model that frames each command with one link clock pulse.
`timescale 1ns/10ps
module sdcai_ctrl_model (
   input  wire logic                 i_mclk,
   input  wire logic                 i_go,
   input  wire sdcai_pkg::sdcai_ca_t i_cmd,
   output logic                      o_ck,
   output sdcai_pkg::sdcai_ca_t      o_ca
);
   import sdcai_pkg::*;
   int cnt;
   initial begin
      cnt = 9;
      o_ck = 1'b0;
      o_ca = '1;
   end
   always @(posedge i_mclk) begin
      if (i_go) begin
         cnt <= 0;
         o_ca <= i_cmd;
      end else if (cnt < 9) begin
         cnt <= cnt + 1;
         o_ck <= cnt >= 1 && cnt < 5;
         if (cnt == 8) o_ca <= ~o_ca;
      end
   end
endmodule // sdcai_ctrl_model

// ==== tb/sdcai_top_test.sv ====
// Self-checking bench of the DRAM command interface.
`timescale 1ns/10ps
module sdcai_top_test;
   import sdcai_pkg::*;
   logic          mclk, rst_n, pin_n, cke, termination_enable, wv, rdy, go, ck, acc_v, wb_v, ovf, ca_en, ck_en;
   logic          odt_on, tog;
   sdcai_ca_t     cmd, ca;
   sdcai_wbeat_t  wb;
   sdcai_access_t acc, got, q[$];
   logic [15:0]   wdata;
   logic [1:0]    we, pw;
   logic [7:0]    open, exp_open;
   logic [13:0]   mr[4], rows[8];
   logic [31:0]   seed, r;
   logic [63:0]   e[8];
   int            failures, tests_run;
   sdcai_ctrl_model u_sdcai_ctrl_model (.i_mclk(mclk), .i_go(go), .i_cmd(cmd), .o_ck(ck),
      .o_ca(ca));
   sdcai_top u_sdcai_top (.i_mclk(mclk), .i_rst_n(rst_n), .i_link_ck(ck), .i_clock_enable_pin(cke),
      .i_reset_pin_n(pin_n), .i_termination_enable(termination_enable), .i_ca(ca), .i_wbeat(wb),
      .i_wbeat_valid(wv),
      .i_acc_ready(rdy), .o_acc_valid(acc_v), .o_acc(acc), .o_wbeat_valid(wb_v), .o_wdata(wdata),
      .o_byte_we(we), .o_bank_open(open), .o_power_state(pw), .o_ca_buf_en(ca_en),
      .o_ck_buf_en(ck_en), .o_odt_on(odt_on), .o_strobe_toggle(tog), .o_overflow(ovf));
   // ****
   // Tasks
   // ****
   always #25 mclk = ~mclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [63:0] g, input logic [63:0] x);
      tests_run++;
      if (g !== x) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
      logic [3:0] bl;
      bl = (mr[0][1:0] == 2'h1 && !a[12]) ? 4'h4 : 4'h8;
      cmd <= {c, ba, a};
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      case (c)
         4'h0: if (ba < 4) mr[ba] = a;
         4'h2: exp_open = a[10] ? 8'h0 : exp_open & ~(8'h1 << ba);
         4'h3: begin
            exp_open[ba] = 1'b1;
            rows[ba] = a;
         end
         4'h4, 4'h5: if (rdy || q.size() < 2) begin
            q.push_back({~c[0], ba, rows[ba], 4'h0, a[9:0], a[10], bl});
            if (a[10]) exp_open[ba] = 1'b0;
         end
         default: ;
      endcase
      repeat (13) @(posedge mclk);
      check(open, exp_open);
   endtask
   always @(posedge mclk) begin
      if (acc_v === 1'b1 && rdy === 1'b1) begin
         got = acc;
         got.column[13:10] = 4'h0;
         check(got, q.size() ? q.pop_front() : '1);
      end
   end
   initial begin
      #300000;
      failures++;
      give_verdict();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      {mclk, rst_n, go, termination_enable, wv} = '0;
      {pin_n, cke, rdy} = '1;
      {cmd, wb, exp_open, mr[0], mr[1], failures, tests_run} = '0;
      seed = 32'h60ED;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      check({pw, ca_en, ck_en, odt_on}, 5'h6);
      issue(4'h0, 3'h0, 14'h0001);
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         issue(4'h3, r[2:0], r[16:3]);
         issue({3'h2, r[20]}, r[2:0], r[21:8]);
      end
      issue(4'hB, 3'h5, 14'h0);
      issue(4'h2, r[2:0], 14'h0);
      issue(4'h3, 3'h1, 14'h0123);
      rdy <= 1'b0;
      repeat (3) issue(4'h5, 3'h1, 14'h0010);
      check(ovf, 1'b1);
      rdy <= 1'b1;
      repeat (4) @(posedge mclk);
      check(q.size(), 0);
      wv <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         if (i > 1) check({wb_v, wdata, we}, e[i-2]);
         r = rnd();
         wb <= {r[15:0], i[1], i[0]};
         e[i] = {i < 3, r[15:0], ~i[0] && i < 3, ~i[1] && i < 3};
         if (i == 3) wv <= 1'b0;
      end
      termination_enable <= 1'b1;
      issue(4'h7, 3'h0, 14'h0);
      check(odt_on, 1'b0);
      issue(4'h0, 3'h1, 14'h0004);
      issue(4'h7, 3'h0, 14'h0);
      check(odt_on, 1'b1);
      termination_enable <= 1'b0;
      cke <= 1'b0;
      issue(4'h7, 3'h0, 14'h0);
      check({pw, ca_en, ck_en}, 4'h9);
      cke <= 1'b1;
      issue(4'h7, 3'h0, 14'h0);
      issue(4'h2, 3'h0, 14'h0400);
      cke <= 1'b0;
      issue(4'h7, 3'h0, 14'h0);
      check({pw, ca_en, ck_en}, 4'h5);
      cke <= 1'b1;
      issue(4'h7, 3'h0, 14'h0);
      cke <= 1'b0;
      issue(4'h1, 3'h0, 14'h0);
      check({pw, ca_en, ck_en}, 4'hC);
      cke <= 1'b1;
      repeat (8) @(posedge mclk);
      check({pw, ca_en, ck_en}, 4'h3);
      issue(4'h3, 3'h6, 14'h0042);
      pin_n <= 1'b0;
      repeat (6) @(posedge mclk);
      pin_n <= 1'b1;
      repeat (6) @(posedge mclk);
      check(open, 8'h0);
      give_verdict();
   end
endmodule // sdcai_top_test
